// [shared/pioc_pkg.sv]
// pioc_pkg: register map, response codes and sizes of the line configuration block
package pioc_pkg;
   localparam int          PIOC_LINES     = 32;
   localparam int          PIOC_AW        = 8;
   localparam logic [7:0]  PIOC_OD_EN     = 8'h00;
   localparam logic [7:0]  PIOC_OD_DIS    = 8'h04;
   localparam logic [7:0]  PIOC_OD_STATE  = 8'h08;
   localparam logic [7:0]  PIOC_PU_DIS    = 8'h0c;
   localparam logic [7:0]  PIOC_PU_EN     = 8'h10;
   localparam logic [7:0]  PIOC_PU_STATE  = 8'h14;
   localparam logic [7:0]  PIOC_FA_SEL    = 8'h18;
   localparam logic [7:0]  PIOC_FB_SEL    = 8'h1c;
   localparam logic [7:0]  PIOC_FN_STATE  = 8'h20;
   localparam logic [7:0]  PIOC_OW_EN     = 8'h24;
   localparam logic [7:0]  PIOC_OW_DIS    = 8'h28;
   localparam logic [7:0]  PIOC_OW_STATE  = 8'h2c;
   localparam logic [7:0]  PIOC_IRQ_EN    = 8'h30;
   localparam logic [7:0]  PIOC_IRQ_DIS   = 8'h34;
   localparam logic [7:0]  PIOC_IRQ_MASK  = 8'h38;
   localparam logic [7:0]  PIOC_CHG_STAT  = 8'h3c;
   localparam logic [7:0]  PIOC_OUT_DATA  = 8'h40;
   localparam logic [31:0] PIOC_ZERO      = 32'h0000_0000;
   localparam logic [31:0] PIOC_ONES      = 32'hffff_ffff;
   localparam logic [1:0]  PIOC_RESP_OK   = 2'b00;
   localparam logic [1:0]  PIOC_RESP_SLV  = 2'b10;
   localparam logic [1:0]  PIOC_WORD_LSB  = 2'b00;
endpackage

// [shared/pioc_sync_if.sv]
// pioc_sync_if: raw pad levels in, filtered levels and change events out
`timescale 1ns/1ps
`default_nettype none
interface pioc_sync_if;
   logic [31:0] raw;
   logic [31:0] level;
   logic [31:0] change;
   modport filt (input raw, output level, output change);
   modport user (output raw, input level, input change);
endinterface
`default_nettype wire

// [design/pioc_pin_sync.sv]
// pioc_pin_sync: three-stage pad synchroniser with per-line change detection
`timescale 1ns/1ps
`default_nettype none
module pioc_pin_sync
   import pioc_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   sys_rst,
   input  wire logic   clk_en,
   pioc_sync_if.filt   sif
);
   typedef struct packed
   {
      logic [31:0] s1;
      logic [31:0] s2;
      logic [31:0] s3;
      logic [31:0] lvl;
      logic [31:0] chg;
   } pioc_sync_t;

   pioc_sync_t st_q;
   pioc_sync_t st_d;

   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = sif.raw;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // only accept a level once stages two and three agree
      st_d.chg = (st_q.s2 ~^ st_q.s3) & (st_q.s2 ^ st_q.lvl);
      st_d.lvl = st_q.lvl ^ st_d.chg;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         st_q <= '0;
      else if (clk_en)
         st_q <= st_d;
   end

   assign sif.level  = st_q.lvl;
   assign sif.change = st_q.chg;
endmodule
`default_nettype wire

// [design/pioc_line_cfg.sv]
// pioc_line_cfg: per-line pad configuration and change status behind AXI4-Lite
//
// Behaviour
// R01: a detected input level change sets that line's change-status bit.
// R02: change-status bits are zero after reset and clear when the register is read.
// R03: a one written to open-drain enable turns on open drain for that line, zeros do nothing.
// R04: a one written to open-drain disable turns off open drain for that line, zeros do nothing.
// R05: open-drain state reads one when enabled and the pad is then only driven low.
// R06: open-drain state reads zero when disabled and the pad is driven high and low.
// R07: a one written to pull-up disable switches that line's pull-up off.
// R08: a one written to pull-up enable switches that line's pull-up on.
// R09: pull-up state reads zero when the pull-up is on and one when it is off.
// R10: a one written to function A select assigns that line to function A.
// R11: a one written to function B select assigns that line to function B.
// R12: function state reads zero for function A and one for function B.
// R13: a one written to output-write enable lets output-data writes update that line.
// R14: output-write state reads one where output-data writes take effect.
// R15: the interrupt mask holds one per line where the change interrupt is enabled.
// R16: the interrupt output is high while any line has change status and mask both set.
// R17: each bit acts only on the line of the same index.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pioc_line_cfg
   import pioc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pads
   input  wire logic [31:0] pad_in,
   output logic [31:0]      pad_out,
   output logic [31:0]      pad_oe,
   output logic [31:0]      pad_pullup_en,
   // peripheral function muxing
   input  wire logic [31:0] func_a_out,
   input  wire logic [31:0] func_a_oe,
   input  wire logic [31:0] func_b_out,
   input  wire logic [31:0] func_b_oe,
   input  wire logic [31:0] line_gpio_sel,
   input  wire logic [31:0] line_gpio_oe,
   output logic [31:0]      line_bits,
   output logic             change_irq
);
   typedef struct packed
   {
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [31:0] chg_stat;
      logic [31:0] od_en;
      logic [31:0] pu_off;
      logic [31:0] fn_b;
      logic [31:0] ow_en;
      logic [31:0] irq_mask;
      logic [31:0] out_data;
      logic [31:0] pad_out;
      logic [31:0] pad_oe;
      logic [31:0] pad_pu;
      logic [31:0] lvl;
      logic        irq;
   } pioc_state_t;

   pioc_state_t st_q;
   pioc_state_t st_d;

   pioc_sync_if sif ();

   assign sif.raw = pad_in;

   pioc_pin_sync u_sync
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .sif      (sif)
   );

   // ************************************************************
   // write strobes per register
   // ************************************************************
   logic        wr_fire;
   logic        rd_fire;
   logic [31:0] wmask;
   logic [31:0] wr1;
   logic        wr_hit;
   logic [31:0] rd_val;
   logic        rd_hit;
   logic [31:0] drv_val;
   logic [31:0] drv_oe;

   // byte strobes widen to a bit mask so a partial write only touches its lanes
   genvar gi;
   generate
      for (gi = 0; gi < PIOC_LINES; gi++)
      begin : g_mask
         assign wmask[gi] = st_q.w_strb[gi / 8];
      end
   endgenerate

   assign wr_fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;
   assign rd_fire = s_axi_arvalid && !st_q.rvalid;
   assign wr1     = st_q.w_data & wmask;

   // ************************************************************
   // read mux
   // ************************************************************
   always_comb
   begin
      rd_val = PIOC_ZERO;
      rd_hit = 1'b1;
      if (s_axi_araddr[1:0] != PIOC_WORD_LSB)
         rd_hit = 1'b0;
      else
      begin
         unique case (s_axi_araddr)
            PIOC_OD_STATE : rd_val = st_q.od_en;    // [R05] [R06]
            PIOC_PU_STATE : rd_val = st_q.pu_off;   // [R09]
            PIOC_FN_STATE : rd_val = st_q.fn_b;     // [R12]
            PIOC_OW_STATE : rd_val = st_q.ow_en;    // [R14]
            PIOC_IRQ_MASK : rd_val = st_q.irq_mask; // [R15]
            PIOC_CHG_STAT : rd_val = st_q.chg_stat;
            PIOC_OUT_DATA : rd_val = st_q.out_data;
            PIOC_OD_EN, PIOC_OD_DIS, PIOC_PU_DIS, PIOC_PU_EN, PIOC_FA_SEL,
            PIOC_FB_SEL, PIOC_OW_EN, PIOC_OW_DIS, PIOC_IRQ_EN, PIOC_IRQ_DIS :
               rd_val = PIOC_ZERO;
            default : rd_hit = 1'b0;
         endcase
      end
   end

   // write address decode; read-only registers still answer okay
   always_comb
   begin
      wr_hit = 1'b1;
      if (st_q.aw_addr[1:0] != PIOC_WORD_LSB)
         wr_hit = 1'b0;
      else
      begin
         unique case (st_q.aw_addr)
            PIOC_OD_EN, PIOC_OD_DIS, PIOC_PU_DIS, PIOC_PU_EN, PIOC_FA_SEL,
            PIOC_FB_SEL, PIOC_OW_EN, PIOC_OW_DIS, PIOC_IRQ_EN, PIOC_IRQ_DIS,
            PIOC_OUT_DATA, PIOC_OD_STATE, PIOC_PU_STATE, PIOC_FN_STATE,
            PIOC_OW_STATE, PIOC_IRQ_MASK, PIOC_CHG_STAT :
               wr_hit = 1'b1;
            default : wr_hit = 1'b0;
         endcase
      end
   end

   // ************************************************************
   // pad drive: function mux, then open-drain shaping
   // ************************************************************
   generate
      for (gi = 0; gi < PIOC_LINES; gi++)
      begin : g_line
         logic v;
         logic e;
         // [R17] each line selects from its own bit only
         always_comb
         begin
            v = 1'b0;
            e = 1'b0;
            if (line_gpio_sel[gi])
            begin
               v = st_q.out_data[gi];
               e = line_gpio_oe[gi];
            end
            else if (st_q.fn_b[gi])
            begin
               v = func_b_out[gi];
               e = func_b_oe[gi];
            end
            else
            begin
               v = func_a_out[gi];
               e = func_a_oe[gi];
            end
         end
         // open drain drives only the low level, else push-pull [R05] [R06]
         assign drv_val[gi] = st_q.od_en[gi] ? 1'b0 : v;
         assign drv_oe[gi]  = st_q.od_en[gi] ? (e & ~v) : e;
      end
   endgenerate

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_d = st_q;

      if (s_axi_awvalid && !st_q.aw_got)
      begin
         st_d.aw_got  = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.w_got)
      begin
         st_d.w_got  = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_strb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready)
         st_d.bvalid = 1'b0;
      if (st_q.rvalid && s_axi_rready)
         st_d.rvalid = 1'b0;

      if (wr_fire)
      begin
         st_d.aw_got = 1'b0;
         st_d.w_got  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = wr_hit ? PIOC_RESP_OK : PIOC_RESP_SLV;
         if (wr_hit)
         begin
            unique case (st_q.aw_addr)
               PIOC_OD_EN   : st_d.od_en    = st_q.od_en | wr1;     // [R03]
               PIOC_OD_DIS  : st_d.od_en    = st_q.od_en & ~wr1;    // [R04]
               PIOC_PU_DIS  : st_d.pu_off   = st_q.pu_off | wr1;    // [R07]
               PIOC_PU_EN   : st_d.pu_off   = st_q.pu_off & ~wr1;   // [R08]
               PIOC_FA_SEL  : st_d.fn_b     = st_q.fn_b & ~wr1;     // [R10]
               PIOC_FB_SEL  : st_d.fn_b     = st_q.fn_b | wr1;      // [R11]
               PIOC_OW_EN   : st_d.ow_en    = st_q.ow_en | wr1;     // [R13]
               PIOC_OW_DIS  : st_d.ow_en    = st_q.ow_en & ~wr1;
               PIOC_IRQ_EN  : st_d.irq_mask = st_q.irq_mask | wr1;  // [R15]
               PIOC_IRQ_DIS : st_d.irq_mask = st_q.irq_mask & ~wr1; // [R15]
               // direct data write only lands on write-enabled lines [R13]
               PIOC_OUT_DATA : st_d.out_data = (st_q.out_data & ~(wmask & st_q.ow_en))
                                             | (st_q.w_data & wmask & st_q.ow_en);
               default : st_d.bresp = PIOC_RESP_OK;
            endcase
         end
      end

      if (rd_fire)
      begin
         st_d.rvalid = 1'b1;
         st_d.rdata  = rd_val;
         st_d.rresp  = rd_hit ? PIOC_RESP_OK : PIOC_RESP_SLV;
      end

      // read clears, but a change in the same cycle survives [R02] [R01]
      if (rd_fire && rd_hit && s_axi_araddr == PIOC_CHG_STAT)
         st_d.chg_stat = sif.change;                               // [R02]
      else
         st_d.chg_stat = st_q.chg_stat | sif.change;               // [R01]

      st_d.lvl     = sif.level;
      st_d.pad_out = drv_val;
      st_d.pad_oe  = drv_oe;
      st_d.pad_pu  = ~st_d.pu_off;                                 // [R09]
      st_d.irq     = |(st_d.chg_stat & st_d.irq_mask);             // [R16]
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
      end
      else if (clk_en)
         st_q <= st_d;
   end

   assign s_axi_awready = !st_q.aw_got;
   assign s_axi_wready  = !st_q.w_got;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = st_q.rdata;
   assign s_axi_rresp   = st_q.rresp;
   assign pad_out       = st_q.pad_out;
   assign pad_oe        = st_q.pad_oe;
   assign pad_pullup_en = st_q.pad_pu;
   assign line_bits     = st_q.lvl;
   assign change_irq    = st_q.irq;
endmodule
`default_nettype wire

// [bench/pioc_line_cfg_sva.sv]
// pioc_line_cfg_sva: bus handshake and reset checks on the top ports
`timescale 1ns/1ps
`default_nettype none
module pioc_line_cfg_sva (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [31:0] pad_pullup_en,
   input wire logic        change_irq
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // ****
   // handshakes
   // ****
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved while waiting");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
   // awready rises again as soon as the write fires, even while bvalid waits
   a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address taken twice");
   a_w_refused: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("write data taken twice");
   // ****
   // reset state
   // ****
   a_pullup_reset: assert property ($fell(sys_rst) |-> ##1 pad_pullup_en == 32'hffff_ffff)
      else $error("pull-ups not on after reset");
   a_irq_quiet: assert property ($fell(sys_rst) |-> !change_irq ##1 !change_irq)
      else $error("interrupt high after reset");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_irq: cover property ($rose(change_irq));
endmodule
`default_nettype wire

// [bench/pioc_pad_model.sv]
// pioc_pad_model: pad wires with pull-ups, an outside driver and floating lines
`timescale 1ns/1ps
`default_nettype none
module pioc_pad_model (
   input  wire logic        core_clk,
   input  wire logic [31:0] pad_out,
   input  wire logic [31:0] pad_oe,
   input  wire logic [31:0] pad_pullup_en,
   input  wire logic [31:0] ext_val,
   input  wire logic [31:0] ext_oe,
   output logic [31:0]      pad_in
);
   logic tog = 1'h0;
   // a released, unpulled line must not hold its last level
   always @(posedge core_clk) tog <= ~tog;
   assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_oe & ext_val |
      ~ext_oe & (pad_pullup_en | {16{tog, ~tog}}));
endmodule
`default_nettype wire

// [bench/pioc_line_cfg_tb.sv]
// pioc_line_cfg_tb: register, pad and change tests of the line configuration block
`timescale 1ns/1ps
`default_nettype none
module pioc_line_cfg_tb
   import pioc_pkg::*;
;
   logic        core_clk = 0;
   logic        sys_rst = 1;
   logic        clk_en = 1;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, change_irq;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, pad_in, pad_out, pad_oe, pad_pullup_en, line_bits;
   logic [31:0] func_a_out = '0, func_a_oe = '0, func_b_out = '0, func_b_oe = '0;
   logic [31:0] line_gpio_sel = '1, line_gpio_oe = '0, ext_val = '0, ext_oe = '1;
   logic [31:0] st [5];
   logic [31:0] odv, d, t, q;
   int          miscompares = 0, cmp_count = 0, k;
   localparam logic [7:0] SET [5] = '{PIOC_OD_EN, PIOC_PU_DIS, PIOC_FB_SEL, PIOC_OW_EN, PIOC_IRQ_EN};
   localparam logic [7:0] CLR [5] = '{PIOC_OD_DIS, PIOC_PU_EN, PIOC_FA_SEL, PIOC_OW_DIS, PIOC_IRQ_DIS};
   localparam logic [7:0] STA [5] = '{PIOC_OD_STATE, PIOC_PU_STATE, PIOC_FN_STATE, PIOC_OW_STATE,
      PIOC_IRQ_MASK};
   pioc_line_cfg pioc_line_cfg_inst (.core_clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe, .pad_pullup_en,
      .func_a_out, .func_a_oe, .func_b_out, .func_b_oe, .line_gpio_sel, .line_gpio_oe,
      .line_bits, .change_irq);
   pioc_pad_model pioc_pad_model_inst (.core_clk, .pad_out, .pad_oe, .pad_pullup_en, .ext_val,
      .ext_oe, .pad_in);
   initial forever #5 core_clk = ~core_clk;
   // ****
   // helpers
   // ****
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // ready is looked at mid-cycle, so it is the value the next rising edge samples
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] dd,
      output logic [31:0] rq, output logic [1:0] rr);
      int n;
      logic ta, tw, tr, dn;
      n = 0;
      dn = 0;
      s_axi_awaddr <= w ? a : s_axi_awaddr;
      s_axi_araddr <= w ? s_axi_araddr : a;
      s_axi_wdata <= dd;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      while (!dn)
      begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         dn = w ? s_axi_bvalid : s_axi_rvalid;
         rq = s_axi_rdata;
         rr = w ? s_axi_bresp : s_axi_rresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tr) s_axi_arvalid <= 1'h0;
         if (dn) s_axi_bready <= 1'h0;
         if (dn) s_axi_rready <= 1'h0;
         n++;
         if (n > 100)
         begin
            miscompares++;
            wrap_up();
         end
      end
      // spare edge: the next call must not reassign bready or rready in this step
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dd);
      axi(1'h1, a, dd, q, r);
      chk("bresp", {30'h0, PIOC_RESP_OK}, {30'h0, r});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      axi(1'h0, a, '0, q, r);
      chk("rresp", {30'h0, PIOC_RESP_OK}, {30'h0, r});
      chk("rdata", e, q);
   endtask
   function automatic logic [31:0] drv_val();
      return line_gpio_sel & odv | ~line_gpio_sel & (st[2] & func_b_out | ~st[2] & func_a_out);
   endfunction
   function automatic logic [31:0] drv_en();
      logic [31:0] e;
      e = line_gpio_sel & line_gpio_oe | ~line_gpio_sel & (st[2] & func_b_oe | ~st[2] & func_a_oe);
      return e & ~(st[0] & drv_val());
   endfunction
   // ****
   // tests
   // ****
   initial
   begin
      d = $urandom(82088);
      st = '{default: '0};
      odv = '0;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      for (k = 0; k < 5; k++)
      begin
         wr(SET[k], '0);
         wr(CLR[k], '0);
         rd(STA[k], '0);
         rd(SET[k], '0);
      end
      rd(PIOC_CHG_STAT, '0);
      chk("pullup", '1, pad_pullup_en);
      s_axi_wstrb <= 4'h3;
      wr(PIOC_OD_EN, '1);
      s_axi_wstrb <= 4'hf;
      rd(PIOC_OD_STATE, 32'h0000_ffff);
      wr(PIOC_OD_DIS, '1);
      rd(PIOC_OD_STATE, '0);
      axi(1'h1, 8'h44, '0, q, r);
      chk("bresp", {30'h0, PIOC_RESP_SLV}, {30'h0, r});
      axi(1'h0, 8'h41, '0, q, r);
      chk("rresp", {30'h0, PIOC_RESP_SLV}, {30'h0, r});
      $display("test reset and map done");
      repeat (40)
      begin
         k = $urandom_range(4);
         d = $urandom;
         t = $urandom;
         wr(t[0] ? SET[k] : CLR[k], d);
         st[k] = t[0] ? st[k] | d : st[k] & ~d;
         d = $urandom;
         wr(PIOC_OUT_DATA, d);
         odv = odv & ~st[3] | d & st[3];
         func_a_out <= $urandom;
         func_a_oe <= $urandom;
         func_b_out <= $urandom;
         func_b_oe <= $urandom;
         line_gpio_sel <= $urandom;
         line_gpio_oe <= $urandom;
         ext_val <= $urandom;
         ext_oe <= $urandom;
         for (int j = 0; j < 5; j++) rd(STA[j], st[j]);
         chk("pad_oe", drv_en(), pad_oe);
         chk("pad_out", drv_val() & ~st[0] & drv_en(), pad_out & drv_en());
         chk("pullup", ~st[1], pad_pullup_en);
      end
      $display("test random walk done");
      ext_oe <= '1;
      line_gpio_sel <= '1;
      line_gpio_oe <= '0;
      repeat (12) @(posedge core_clk);
      axi(1'h0, PIOC_CHG_STAT, '0, q, r);
      for (int i = 0; i < 4; i++)
      begin
         t = i == 0 ? 32'h8000_0001 : $urandom;
         d = $urandom;
         wr(PIOC_IRQ_DIS, '1);
         wr(PIOC_IRQ_EN, d);
         ext_val <= ext_val ^ t;
         repeat (12) @(posedge core_clk);
         chk("line_bits", ext_val, line_bits);
         chk("irq", {31'h0, |(t & d)}, {31'h0, change_irq});
         rd(PIOC_IRQ_MASK, d);
         rd(PIOC_CHG_STAT, t);
         rd(PIOC_CHG_STAT, '0);
         chk("irq", '0, {31'h0, change_irq});
      end
      $display("test change capture done");
      wrap_up();
   end
endmodule
bind pioc_line_cfg pioc_line_cfg_sva pioc_line_cfg_sva_inst (.core_clk, .sys_rst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pad_pullup_en,
   .change_irq);
`default_nettype wire
